// ==== verilog/ssrg_pkg.sv ====
package ssrg_pkg;

    // timebase
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CNT_W           = 32;
    localparam int SYNC_STAGES     = 3;

    // manual reset filtering
    localparam int GLITCH_TIME_NS  = 100;
    localparam int GLITCH_CYC      = (GLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUALIFY_TIME_NS = 10000;
    localparam int QUALIFY_CYC     = (QUALIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // supply dip acceptance: shallow dips must last longer than deep ones
    localparam int DIP_SHALLOW_TIME_NS = 40000;
    localparam int DIP_SHALLOW_CYC     = (DIP_SHALLOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIP_DEEP_TIME_NS    = 5000;
    localparam int DIP_DEEP_CYC        = (DIP_DEEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // hold delay, typical / min / max, in microseconds
    localparam int HOLD_SHORT_TYP_US = 2190;
    localparam int HOLD_MID_TYP_US   = 35000;
    localparam int HOLD_LONG_TYP_US  = 280000;
    localparam int HOLD_SHORT_MIN_US = 1090;
    localparam int HOLD_MID_MIN_US   = 17500;
    localparam int HOLD_LONG_MIN_US  = 140000;
    localparam int HOLD_SHORT_MAX_US = 4380;
    localparam int HOLD_MID_MAX_US   = 70000;
    localparam int HOLD_LONG_MAX_US  = 560000;

    localparam int NS_PER_US         = 1000;
    localparam int HOLD_SHORT_CYC    = HOLD_SHORT_TYP_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int HOLD_MID_CYC      = HOLD_MID_TYP_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int HOLD_LONG_CYC     = HOLD_LONG_TYP_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int HOLD_SHORT_MIN_CYC =
        (HOLD_SHORT_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_MID_MIN_CYC  =
        (HOLD_MID_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_LONG_MIN_CYC =
        (HOLD_LONG_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_SHORT_MAX_CYC = HOLD_SHORT_MAX_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int HOLD_MID_MAX_CYC  = HOLD_MID_MAX_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int HOLD_LONG_MAX_CYC = HOLD_LONG_MAX_US * NS_PER_US / CLK_PERIOD_NS;

    // reset values
    localparam logic RST_SYNC_LEVEL  = 1'b1;
    localparam logic RST_ACTIVE      = 1'b1;

    typedef enum logic [1:0] {
        OUT_LOW_PUSH_PULL,
        OUT_LOW_OPEN_DRAIN,
        OUT_HIGH_PUSH_PULL
    } ssrg_out_type;

    typedef enum logic [1:0] {
        DLY_SHORT,
        DLY_MID,
        DLY_LONG
    } ssrg_delay_type;

endpackage

// ==== verilog/ssrg_button_filter.sv ====
`timescale 1ns/1ps
module ssrg_button_filter
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // raw button level, pull-up already applied
    input  wire logic pin_level,
    // qualified press
    output logic      press_req
);

    typedef struct packed {
        logic [ssrg_pkg::SYNC_STAGES-1:0] syn;
        logic                             stable;
        logic                             filt;
        logic [ssrg_pkg::CNT_W-1:0]       glitch_cnt;
        logic [ssrg_pkg::CNT_W-1:0]       qual_cnt;
        logic                             press;
    } ssrg_filt_type;

    localparam logic [ssrg_pkg::CNT_W-1:0] GLITCH_LAST =
        ssrg_pkg::CNT_W'(ssrg_pkg::GLITCH_CYC - 1);
    localparam logic [ssrg_pkg::CNT_W-1:0] QUAL_LAST   =
        ssrg_pkg::CNT_W'(ssrg_pkg::QUALIFY_CYC - 1);

    ssrg_filt_type s_q;
    ssrg_filt_type s_d;

    always_comb
    begin
        s_d     = s_q;
        // three stages; only the agreed pair of the last two is trusted
        s_d.syn = {s_q.syn[ssrg_pkg::SYNC_STAGES-2:0], pin_level};
        if (s_q.syn[1] == s_q.syn[2])
        begin
            s_d.stable = s_q.syn[2];
        end
        // a level change must persist for the glitch time before it counts
        if (s_q.stable == s_q.filt)
        begin
            s_d.glitch_cnt = '0;
        end
        else if (s_q.glitch_cnt == GLITCH_LAST)
        begin
            s_d.filt       = s_q.stable;
            s_d.glitch_cnt = '0;
        end
        else
        begin
            s_d.glitch_cnt = s_q.glitch_cnt + 1'b1;
        end
        // press accepted only after a continuous low of the qualify time
        if (s_q.filt)
        begin
            s_d.qual_cnt = '0;
            s_d.press    = 1'b0;
        end
        else if (!s_q.press)
        begin
            if (s_q.qual_cnt == QUAL_LAST)
            begin
                s_d.press = 1'b1;
            end
            else
            begin
                s_d.qual_cnt = s_q.qual_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_q            <= '0;
            s_q.syn        <= {ssrg_pkg::SYNC_STAGES{ssrg_pkg::RST_SYNC_LEVEL}};
            s_q.stable     <= ssrg_pkg::RST_SYNC_LEVEL;
            s_q.filt       <= ssrg_pkg::RST_SYNC_LEVEL;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign press_req = s_q.press;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_press_qualified: assert property ($rose(s_q.press) |-> !$past(s_q.filt))
        else $error("press accepted while filtered level was high");
    a_release_clears: assert property (s_q.filt |=> !s_q.press)
        else $error("press not cleared on release");
    a_short_spike: assert property ($fell(s_q.filt) |->
        $past(s_q.glitch_cnt) == GLITCH_LAST)
        else $error("filtered level fell before the glitch time");

endmodule // ssrg_button_filter

// ==== verilog/ssrg_top.sv ====
// Overview of operation
// - above minimum supply but below trip once the dip is accepted, the reset output is held active.
// - supply rising above trip starts the hold timer; output releases on expiry.
// - supply falling below trip forces reset active once the dip is accepted.
// - short shallow dips are ignored; deeper dips are accepted sooner.
// - reset asserts only after button input stays low for the qualify time.
// - after a button reset, full hold delay counts from button release.
// - button low spikes under about 100 ns have no effect.
// - an undriven button input reads high through an internal pull-up.
// - under-voltage and qualified button press are ORed into one request.
// - hold timer starts only when both requests are inactive.
// - output is active while the hold timer runs, inactive on expiry.
// - a new request during the hold timer clears it; output stays active.
// - hold delay is one of 2.19 ms, 35 ms or 280 ms by option.
// - hold delay lies within its option's min and max bounds.
// - push-pull variants drive active level, then inactive level after delay.
// - open-drain variant floats when inactive; system supplies the pull-up.
`timescale 1ns/1ps
module ssrg_top
#(
    parameter ssrg_pkg::ssrg_out_type   OUT_KIND       = ssrg_pkg::OUT_LOW_PUSH_PULL,
    parameter ssrg_pkg::ssrg_delay_type DELAY_SEL      = ssrg_pkg::DLY_LONG,
    parameter int                       HOLD_SHORT_CYC = ssrg_pkg::HOLD_SHORT_CYC,
    parameter int                       HOLD_MID_CYC   = ssrg_pkg::HOLD_MID_CYC,
    parameter int                       HOLD_LONG_CYC  = ssrg_pkg::HOLD_LONG_CYC
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // supply comparators
    input  wire logic supply_valid,
    input  wire logic below_trip,
    input  wire logic dip_deep,
    // manual reset pin
    input  wire logic push_button_reset_n,
    input  wire logic push_button_float,
    // reset output pin
    output logic      reset_pin_out,
    output logic      reset_pin_oe_n,
    // status
    output logic      reset_active
);

    typedef enum logic [1:0] {
        ST_ASSERT,
        ST_DELAY,
        ST_RELEASED
    } ssrg_state_type;

    // supply input indices into the synchroniser array
    localparam int IN_VALID = 0;
    localparam int IN_BELOW = 1;
    localparam int IN_DEEP  = 2;
    localparam int N_IN     = 3;

    localparam int SEL_HOLD =
        (DELAY_SEL == ssrg_pkg::DLY_SHORT) ? HOLD_SHORT_CYC :
        (DELAY_SEL == ssrg_pkg::DLY_MID)   ? HOLD_MID_CYC   : HOLD_LONG_CYC;
    localparam logic [ssrg_pkg::CNT_W-1:0] HOLD_LAST =
        ssrg_pkg::CNT_W'(SEL_HOLD - 1);
    localparam logic [ssrg_pkg::CNT_W-1:0] SHALLOW_LAST =
        ssrg_pkg::CNT_W'(ssrg_pkg::DIP_SHALLOW_CYC - 1);
    localparam logic [ssrg_pkg::CNT_W-1:0] DEEP_LAST =
        ssrg_pkg::CNT_W'(ssrg_pkg::DIP_DEEP_CYC - 1);

    // option window is scaled to the chosen count, so shortened counts keep their ratios
    localparam longint SEL_TYP_US =
        (DELAY_SEL == ssrg_pkg::DLY_SHORT) ? ssrg_pkg::HOLD_SHORT_TYP_US :
        (DELAY_SEL == ssrg_pkg::DLY_MID)   ? ssrg_pkg::HOLD_MID_TYP_US   :
                                             ssrg_pkg::HOLD_LONG_TYP_US;
    localparam longint SEL_MIN_US =
        (DELAY_SEL == ssrg_pkg::DLY_SHORT) ? ssrg_pkg::HOLD_SHORT_MIN_US :
        (DELAY_SEL == ssrg_pkg::DLY_MID)   ? ssrg_pkg::HOLD_MID_MIN_US   :
                                             ssrg_pkg::HOLD_LONG_MIN_US;
    localparam longint SEL_MAX_US =
        (DELAY_SEL == ssrg_pkg::DLY_SHORT) ? ssrg_pkg::HOLD_SHORT_MAX_US :
        (DELAY_SEL == ssrg_pkg::DLY_MID)   ? ssrg_pkg::HOLD_MID_MAX_US   :
                                             ssrg_pkg::HOLD_LONG_MAX_US;
    localparam longint HOLD_MIN   = longint'(SEL_HOLD) * SEL_MIN_US / SEL_TYP_US;
    localparam longint HOLD_MAX   = longint'(SEL_HOLD) * SEL_MAX_US / SEL_TYP_US;

    typedef struct packed {
        logic [N_IN-1:0][ssrg_pkg::SYNC_STAGES-1:0] syn;
        logic [N_IN-1:0]                            stable;
        logic [ssrg_pkg::CNT_W-1:0]                 shallow_cnt;
        logic [ssrg_pkg::CNT_W-1:0]                 deep_cnt;
        logic                                       uv;
        ssrg_state_type                             state;
        logic [ssrg_pkg::CNT_W-1:0]                 hold_cnt;
        logic                                       active;
        logic                                       pin_out;
        logic                                       pin_oe_n;
        logic [ssrg_pkg::CNT_W-1:0]                 quiet;
    } ssrg_top_type;

    ssrg_top_type s_q;
    ssrg_top_type s_d;

    logic pin_level;
    logic press_req;
    logic request;

    // pin value seen when nothing drives the button is the pulled-up high
    assign pin_level = push_button_float ? 1'b1 : push_button_reset_n;

    ssrg_button_filter u_button
    (
        .clk       (clk),
        .rstn      (rstn),
        .pin_level (pin_level),
        .press_req (press_req)
    );

    // pin drive for a given reset state; open-drain only ever pulls low
    function automatic logic [1:0] pin_drive(input logic act);
        logic [1:0] r;
        r = 2'h0;
        case (OUT_KIND)
            ssrg_pkg::OUT_LOW_PUSH_PULL:  r = {~act, 1'b0};
            ssrg_pkg::OUT_HIGH_PUSH_PULL: r = {act, 1'b0};
            ssrg_pkg::OUT_LOW_OPEN_DRAIN: r = {1'b0, ~act};
            default:                      r = {~act, 1'b0};
        endcase
        return r;
    endfunction

    assign request = s_q.uv | press_req;

    always_comb
    begin
        s_d = s_q;
        for (int k = 0; k < N_IN; k++)
        begin
            s_d.syn[k] = {s_q.syn[k][ssrg_pkg::SYNC_STAGES-2:0],
                          (k == IN_VALID) ? supply_valid :
                          (k == IN_BELOW) ? below_trip : dip_deep};
            if (s_q.syn[k][1] == s_q.syn[k][2])
            begin
                s_d.stable[k] = s_q.syn[k][2];
            end
        end

        // dip acceptance: a timer per overdrive band, the deep one is shorter
        if (!s_q.stable[IN_BELOW])
        begin
            s_d.shallow_cnt = '0;
            s_d.deep_cnt    = '0;
        end
        else
        begin
            if (s_q.shallow_cnt != SHALLOW_LAST)
            begin
                s_d.shallow_cnt = s_q.shallow_cnt + 1'b1;
            end
            if (!s_q.stable[IN_DEEP])
            begin
                s_d.deep_cnt = '0;
            end
            else if (s_q.deep_cnt != DEEP_LAST)
            begin
                s_d.deep_cnt = s_q.deep_cnt + 1'b1;
            end
        end
        if (!s_q.stable[IN_VALID])
        begin
            s_d.uv = 1'b1;
        end
        else if (!s_q.stable[IN_BELOW])
        begin
            s_d.uv = 1'b0;
        end
        else if ((s_q.shallow_cnt == SHALLOW_LAST) ||
                 (s_q.stable[IN_DEEP] && s_q.deep_cnt == DEEP_LAST))
        begin
            s_d.uv = 1'b1;
        end

        case (s_q.state)
            ST_ASSERT:
            begin
                s_d.hold_cnt = '0;
                if (!request)
                begin
                    s_d.state = ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                if (request)
                begin
                    s_d.state    = ST_ASSERT;
                    s_d.hold_cnt = '0;
                end
                else if (s_q.hold_cnt == HOLD_LAST)
                begin
                    s_d.state = ST_RELEASED;
                end
                else
                begin
                    s_d.hold_cnt = s_q.hold_cnt + 1'b1;
                end
            end
            ST_RELEASED:
            begin
                if (request)
                begin
                    s_d.state    = ST_ASSERT;
                    s_d.hold_cnt = '0;
                end
            end
            default:
            begin
                s_d.state = ST_ASSERT;
            end
        endcase

        // request-free cycle count, only read by the hold checks
        if (request)
        begin
            s_d.quiet = '0;
        end
        else if (s_q.quiet != '1)
        begin
            s_d.quiet = s_q.quiet + 1'b1;
        end

        // outputs follow the next state so a request shows one edge later
        s_d.active                 = (s_d.state != ST_RELEASED);
        {s_d.pin_out, s_d.pin_oe_n} = pin_drive(s_d.active);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_q                        <= '0;
            s_q.syn                    <= '0;
            s_q.uv                     <= ssrg_pkg::RST_ACTIVE;
            s_q.state                  <= ST_ASSERT;
            s_q.active                 <= ssrg_pkg::RST_ACTIVE;
            {s_q.pin_out, s_q.pin_oe_n} <= pin_drive(ssrg_pkg::RST_ACTIVE);
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reset_pin_out  = s_q.pin_out;
    assign reset_pin_oe_n = s_q.pin_oe_n;
    assign reset_active   = s_q.active;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_req_drop;
        request ##1 !request;
    endsequence

    sequence s_req_return;
        (s_q.state == ST_DELAY) ##0 request;
    endsequence

    a_low_supply: assert property (!s_q.stable[IN_VALID] |-> ##2 reset_active)
        else $error("output not active with supply below minimum");
    a_hold_exact: assert property ($fell(reset_active) |-> s_q.quiet == SEL_HOLD + 1)
        else $error("release not at the selected hold count");
    a_uv_immediate: assert property (s_q.uv |=> reset_active && s_q.state == ST_ASSERT)
        else $error("under-voltage did not force reset at once");
    a_dip_accept: assert property ($rose(s_q.uv) && s_q.stable[IN_VALID] |->
        $past(s_q.shallow_cnt) == SHALLOW_LAST || $past(s_q.deep_cnt) == DEEP_LAST)
        else $error("dip accepted before its duration");
    a_press_to_out: assert property (press_req |=> reset_active && s_q.hold_cnt == '0)
        else $error("button request did not hold reset");
    a_timer_start: assert property (s_req_drop |=> s_q.state == ST_DELAY)
        else $error("hold timer did not start when requests cleared");
    a_timer_clear: assert property (s_req_return |=> s_q.state == ST_ASSERT
        && s_q.hold_cnt == '0 && reset_active)
        else $error("request during hold did not clear timer");
    a_delay_active: assert property (s_q.state == ST_DELAY |-> reset_active)
        else $error("output inactive while timer runs");
    a_pin_encode: assert property (
        {reset_pin_out, reset_pin_oe_n} ==
        ((OUT_KIND == ssrg_pkg::OUT_LOW_OPEN_DRAIN) ? {1'b0, ~reset_active} :
         (OUT_KIND == ssrg_pkg::OUT_HIGH_PUSH_PULL) ? {reset_active, 1'b0} :
                                                      {~reset_active, 1'b0}))
        else $error("pin drive does not match reset state");
    a_powerup_held: assert property (!$past(rstn) |-> reset_active &&
        {reset_pin_out, reset_pin_oe_n} ==
        ((OUT_KIND == ssrg_pkg::OUT_HIGH_PUSH_PULL) ? 2'h2 : 2'h0))
        else $error("output not asserted after reset");
    a_hold_bounds: assert property ($fell(reset_active) |->
        s_q.quiet >= HOLD_MIN && s_q.quiet <= HOLD_MAX)
        else $error("hold delay outside its option bounds");
    a_reassert_clear: assert property (s_q.state == ST_RELEASED && request |=>
        s_q.state == ST_ASSERT && s_q.hold_cnt == '0 && reset_active)
        else $error("request after release did not restart from a clear timer");
    a_od_float: assert property ((OUT_KIND == ssrg_pkg::OUT_LOW_OPEN_DRAIN) |->
        !reset_pin_out)
        else $error("open-drain output drove high");

endmodule // ssrg_top

// ==== testbench/ssrg_button_model.sv ====
`timescale 1ns/1ps
module ssrg_button_model
(
    // clock
    input  wire logic       clk,
    // bench commands
    input  wire logic       press_cmd,
    input  wire logic       float_cmd,
    // button pin toward the supervisor
    output logic            push_button_reset_n,
    output logic            push_button_float,
    // reset pins of the supervisors and the line the system sees
    input  wire logic [2:0] reset_pin_out,
    input  wire logic [2:0] reset_pin_oe_n,
    output logic [2:0]      sys_reset_line
);
    logic last_q = 1'b1;

    always @(posedge clk)
    begin
        if (!float_cmd)
            last_q <= push_button_reset_n;
    end

    // an undriven pin shows the inverse of its last level, so only the float flag may save it
    assign push_button_reset_n = float_cmd ? ~last_q : ~press_cmd;
    assign push_button_float   = float_cmd;
    // a released line sits at the board pull-up
    assign sys_reset_line      = reset_pin_oe_n | reset_pin_out;
endmodule // ssrg_button_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    localparam int HOLD[3] = '{50, 80, 120};

    logic       clk = 1'b0;
    logic       rstn;
    logic       supply_valid;
    logic       below_trip;
    logic       dip_deep;
    logic       press_cmd;
    logic       float_cmd;
    logic       button_n;
    logic       button_float;
    logic [2:0] pin_out;
    logic [2:0] pin_oe_n;
    logic [2:0] reset_active;
    logic [2:0] line;
    logic [2:0] prev_act;
    logic       exp_act;
    logic       mon_on = 1'b0;
    logic       exp_q[3][$];
    int         cyc = 0;
    int         t0;
    int         failures = 0;
    int         total_checks = 0;

    always #5 clk = ~clk;

    always @(posedge clk)
        cyc <= cyc + 1;

    ssrg_button_model partner
    (
        .clk                 (clk),
        .press_cmd           (press_cmd),
        .float_cmd           (float_cmd),
        .push_button_reset_n (button_n),
        .push_button_float   (button_float),
        .reset_pin_out       (pin_out),
        .reset_pin_oe_n      (pin_oe_n),
        .sys_reset_line      (line)
    );

    // one unit per output kind, each with its own delay option
    for (genvar i = 0; i < 3; i++)
    begin : g_unit
        ssrg_top
        #(
            .OUT_KIND       (i == 0 ? ssrg_pkg::OUT_LOW_PUSH_PULL :
                             i == 1 ? ssrg_pkg::OUT_LOW_OPEN_DRAIN :
                                      ssrg_pkg::OUT_HIGH_PUSH_PULL),
            .DELAY_SEL      (i == 0 ? ssrg_pkg::DLY_SHORT :
                             i == 1 ? ssrg_pkg::DLY_MID : ssrg_pkg::DLY_LONG),
            .HOLD_SHORT_CYC (50),
            .HOLD_MID_CYC   (80),
            .HOLD_LONG_CYC  (120)
        )
        dut
        (
            .clk                 (clk),
            .rstn                (rstn),
            .supply_valid        (supply_valid),
            .below_trip          (below_trip),
            .dip_deep            (dip_deep),
            .push_button_reset_n (button_n),
            .push_button_float   (button_float),
            .reset_pin_out       (pin_out[i]),
            .reset_pin_oe_n      (pin_oe_n[i]),
            .reset_active        (reset_active[i])
        );
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmp_val(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_time(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("CHECK FAILED t=%0t cycles=%h window=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic test_done();
        // let the monitor take the last output change off the queue first
        tick(1);
        for (int i = 0; i < 3; i++)
            failures += exp_q[i].size();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic expect_all(input logic act);
        for (int i = 0; i < 3; i++)
            exp_q[i].push_back(act);
    endtask

    // bounded wait for one unit, then its latency from t0 against a window
    task automatic wait_inst(input int i, input logic val, input int lo, input int hi);
        int n;
        n = 0;
        while (reset_active[i] !== val && n < hi + 20)
        begin
            tick(1);
            n++;
        end
        if (reset_active[i] !== val)
        begin
            failures++;
            $display("CHECK FAILED t=%0t unit=%0d got=%h exp=%h", $time, i, reset_active[i], val);
            test_done();
        end
        cmp_time(cyc - t0, lo, hi);
    endtask

    task automatic release_all(input int slack);
        expect_all(1'b0);
        t0 = cyc;
        for (int i = 0; i < 3; i++)
            wait_inst(i, 1'b0, HOLD[i] + 1, HOLD[i] + slack);
    endtask

    task automatic assert_all(input int lo, input int hi);
        expect_all(1'b1);
        t0 = cyc;
        for (int i = 0; i < 3; i++)
            wait_inst(i, 1'b1, lo, hi);
    endtask

    // every change of a unit's output must have been announced; the pin follows it
    always @(posedge clk)
    begin
        #2;
        for (int i = 0; i < 3; i++)
        begin
            if (mon_on && reset_active[i] !== prev_act[i])
            begin
                exp_act = exp_q[i].size() == 0 ? prev_act[i] : exp_q[i].pop_front();
                prev_act[i] = reset_active[i];
                cmp_val({2'h0, reset_active[i]}, {2'h0, exp_act});
                cmp_val({2'h0, line[i]}, {2'h0, (i == 2) ? exp_act : ~exp_act});
                cmp_val({2'h0, pin_oe_n[i]}, {2'h0, (i == 1) ? ~exp_act : 1'b0});
            end
        end
    end

    initial
    begin
        rstn = 1'b0;
        supply_valid = 1'b1;
        below_trip = 1'b0;
        dip_deep = 1'b0;
        press_cmd = 1'b0;
        float_cmd = 1'b0;
        void'($urandom(67733));
        tick(8);
        cmp_val(reset_active, 3'h7);
        cmp_val(line, 3'h4);
        cmp_val(pin_oe_n, 3'h0);
        prev_act = reset_active;
        mon_on = 1'b1;
        rstn = 1'b1;
        release_all(20);
        // dips that end before they are accepted
        below_trip = 1'b1;
        tick(1000 + $urandom_range(2500));
        below_trip = 1'b0;
        dip_deep = 1'b1;
        tick(20);
        below_trip = 1'b1;
        tick(100 + $urandom_range(300));
        below_trip = 1'b0;
        tick(20);
        below_trip = 1'b1;
        assert_all(500, 512);
        below_trip = 1'b0;
        release_all(15);
        dip_deep = 1'b0;
        below_trip = 1'b1;
        assert_all(4000, 4012);
        below_trip = 1'b0;
        release_all(15);
        supply_valid = 1'b0;
        assert_all(1, 8);
        // request again in mid-delay restarts the count
        supply_valid = 1'b1;
        tick(10 + $urandom_range(30));
        supply_valid = 1'b0;
        tick(10);
        supply_valid = 1'b1;
        release_all(15);
        // button glitch, short press, floating pin
        press_cmd = 1'b1;
        tick(1 + $urandom_range(5));
        press_cmd = 1'b0;
        tick(30);
        press_cmd = 1'b1;
        tick(20 + $urandom_range(800));
        press_cmd = 1'b0;
        tick(30);
        float_cmd = 1'b1;
        tick(1500);
        float_cmd = 1'b0;
        tick(30);
        press_cmd = 1'b1;
        assert_all(1000, 1020);
        supply_valid = 1'b0;
        tick(30);
        supply_valid = 1'b1;
        tick(100);
        press_cmd = 1'b0;
        release_all(25);
        // second reset in mid-run
        expect_all(1'b1);
        rstn = 1'b0;
        tick(4);
        rstn = 1'b1;
        release_all(20);
        test_done();
    end
endmodule // tb_top
